// File: hw/fsh_pkg.sv
// package: register map, group layout and reset values of the fault status hierarchy
package fsh_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_SUMMARY = 12'h000;
	localparam logic [11:0] OFS_MASK_A = 12'h004;
	localparam logic [11:0] OFS_MASK_B = 12'h008;
	localparam logic [11:0] OFS_CLEAR_A = 12'h00C;
	localparam logic [11:0] OFS_CLEAR_B = 12'h010;
	localparam logic [11:0] OFS_CONFIG = 12'h014;
	localparam logic [11:0] OFS_LOW_BASE = 12'h080;
	localparam logic [11:0] OFS_CMD_DETAIL = 12'h100;
	localparam logic [11:0] OFS_RESP_DETAIL = 12'h104;
	localparam logic [11:0] OFS_NVM_CORR = 12'h108;
	localparam logic [11:0] OFS_NVM_UNCORR = 12'h10C;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_MASK_A = 8'h00;
	localparam logic [7:0] RST_MASK_B = 8'h00;
	localparam logic RST_PIN_ENABLE = 1'b1;

	// ----------------------------------------
	// low-level registers and groups
	// ----------------------------------------
	localparam int NUM_LOW = 24;
	localparam logic [4:0] NUM_LOW_W = 5'd24;
	localparam int NUM_GRP = 11;
	localparam logic [4:0] REG_OTP = 5'd12;
	localparam logic [4:0] REG_LINK = 5'd13;
	localparam logic [2:0] CRC_USER_BIT = 3'd0;
	localparam logic [2:0] CRC_FACT_BIT = 3'd1;

	// group ids follow the clear/mask bit positions, mask_b placed above mask_a
	localparam logic [3:0] GRP_PROT = 4'h0;
	localparam logic [3:0] GRP_UT = 4'h1;
	localparam logic [3:0] GRP_OT = 4'h2;
	localparam logic [3:0] GRP_UV = 4'h3;
	localparam logic [3:0] GRP_OV = 4'h4;
	localparam logic [3:0] GRP_COMP = 4'h5;
	localparam logic [3:0] GRP_SYS = 4'h6;
	localparam logic [3:0] GRP_PWR = 4'h7;
	localparam logic [3:0] GRP_NVM_CRC = 4'h8;
	localparam logic [3:0] GRP_NVM_DATA = 4'h9;
	localparam logic [3:0] GRP_LINK = 4'hA;

	// summary bit positions
	localparam logic [2:0] SUM_PROT = 3'd0;
	localparam logic [2:0] SUM_COMP = 3'd1;
	localparam logic [2:0] SUM_OTP = 3'd2;
	localparam logic [2:0] SUM_LINK = 3'd3;
	localparam logic [2:0] SUM_TEMP = 3'd4;
	localparam logic [2:0] SUM_VOLT = 3'd5;

	// per low-level register, index 23 first
	localparam logic [23:0][3:0] REG_GROUP = {
		GRP_PWR, GRP_PWR, GRP_PWR, GRP_SYS, GRP_UV, GRP_UV, GRP_OV, GRP_OV,
		GRP_UT, GRP_OT, GRP_LINK, GRP_NVM_DATA,
		{10{GRP_COMP}}, GRP_PROT, GRP_PROT};
	localparam logic [23:0][2:0] REG_SUMBIT = {
		3'd7, 3'd7, 3'd7, 3'd6, 3'd5, 3'd5, 3'd5, 3'd5,
		3'd4, 3'd4, 3'd3, 3'd2,
		{10{3'd1}}, 3'd0, 3'd0};

	// ----------------------------------------
	// bus responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// File: hw/fsh_top.sv
// fault status hierarchy: latched fault flags, group masks, summary and fault pin
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps

// Function
// - each summary bit represents one fault group of low-level registers
// - groups: protection 2, compare 10, nvm 1, link 1, temp 2, volt 4, sys 1, power 3
// - command frame error has a latched detail debug register
// - link group has a latched response frame error detail register
// - nvm corrected-block debug register accompanies the single error flag
// - nvm uncorrectable-block debug register accompanies the double error flag
// - fault sets low-level and debug flags, then unmasked group summary bit
// - masked group still latches flags but adds nothing to its summary bit
// - masked faults never pull the fault pin low
// - mask_a holds eight group masks; temp and volt need both masks to suppress
// - mask_b nvm crc mask and nvm data mask both gate nvm summary bit
// - mask_b link mask covers link flags and frame detail registers
// - flags stay latched until software writes their clear bit
// - clear bit wipes all low-level and debug bits of its group
// - summary bit drops only when every unmasked feeding register is clear
// - clear is ignored while the fault condition is still present
// - clear registers use the same bit layout as mask registers
// - with pin enable cleared summary still updates but pin stays high
module fsh_top (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// fault condition levels from the detectors
	input wire logic [191:0] fault_cond,
	input wire logic [7:0] cmd_frame_cond,
	input wire logic [7:0] resp_frame_cond,
	input wire logic [7:0] nvm_corrected_cond,
	input wire logic [7:0] nvm_uncorrectable_cond,
	// fault pin
	output logic fault_out_n
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] flag [0:fsh_pkg::NUM_LOW-1];
	logic [7:0] cmd_frame_error_detail;
	logic [7:0] resp_frame_error_detail;
	logic [7:0] nvm_corrected_block;
	logic [7:0] nvm_uncorrectable_block;
	logic [7:0] fault_group_mask_a;
	logic [7:0] fault_group_mask_b;
	logic fault_pin_enable;
	logic [7:0] group_fault_summary;
	logic [10:0] clr_pulse;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_strb0_q;

	// ----------------------------------------
	// masks and clears per group
	// ----------------------------------------
	wire [10:0] mask_vec = {fault_group_mask_b[2:0], fault_group_mask_a};
	wire [7:0] unmasked_any [0:fsh_pkg::NUM_LOW-1];
	wire [7:0] next_flag [0:fsh_pkg::NUM_LOW-1];

	// one latched flag per bit; condition wins over clear so a live fault stays set
	for (genvar i = 0; i < fsh_pkg::NUM_LOW; i++)
	begin : g_low
		for (genvar b = 0; b < 8; b++)
		begin : g_bit
			localparam bit IS_CRC = (i == int'(fsh_pkg::REG_OTP)) &&
				((b == int'(fsh_pkg::CRC_USER_BIT)) || (b == int'(fsh_pkg::CRC_FACT_BIT)));
			localparam logic [3:0] GRP = IS_CRC ? fsh_pkg::GRP_NVM_CRC : fsh_pkg::REG_GROUP[i];
			wire cond = fault_cond[i*8+b];
			assign next_flag[i][b] = cond | (flag[i][b] & ~clr_pulse[GRP]);
			assign unmasked_any[i][b] = flag[i][b] & ~mask_vec[GRP];
		end
	end

	// one process owns the whole flag array, so every bit has a single driver
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < fsh_pkg::NUM_LOW; i++)
				flag[i] <= 8'h00;
		end
		else if (ce)
		begin
			for (int i = 0; i < fsh_pkg::NUM_LOW; i++)
				flag[i] <= next_flag[i];
		end
	end

	// ----------------------------------------
	// debug detail registers
	// ----------------------------------------
	wire link_clr = clr_pulse[fsh_pkg::GRP_LINK];
	wire nvm_clr = clr_pulse[fsh_pkg::GRP_NVM_DATA];
	wire [7:0] next_cmd = cmd_frame_cond | (cmd_frame_error_detail & {8{~link_clr}});
	wire [7:0] next_resp = resp_frame_cond | (resp_frame_error_detail & {8{~link_clr}});
	wire [7:0] next_corr = nvm_corrected_cond | (nvm_corrected_block & {8{~nvm_clr}});
	wire [7:0] next_uncorr = nvm_uncorrectable_cond |
		(nvm_uncorrectable_block & {8{~nvm_clr}});

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_frame_error_detail <= 8'h00;
			resp_frame_error_detail <= 8'h00;
			nvm_corrected_block <= 8'h00;
			nvm_uncorrectable_block <= 8'h00;
		end
		else if (ce)
		begin
			cmd_frame_error_detail <= next_cmd;
			resp_frame_error_detail <= next_resp;
			nvm_corrected_block <= next_corr;
			nvm_uncorrectable_block <= next_uncorr;
		end
	end

	// ----------------------------------------
	// summary and fault pin
	// ----------------------------------------
	wire link_dbg_any = ~fault_group_mask_b[2] &
		(|{cmd_frame_error_detail, resp_frame_error_detail});
	wire nvm_dbg_any = ~fault_group_mask_b[1] &
		(|{nvm_corrected_block, nvm_uncorrectable_block});
	logic [7:0] next_sum;

	always_comb
	begin
		next_sum = 8'h00;
		for (int i = 0; i < fsh_pkg::NUM_LOW; i++)
			if (|unmasked_any[i])
				next_sum[fsh_pkg::REG_SUMBIT[i]] = 1'b1;
		if (link_dbg_any)
			next_sum[fsh_pkg::SUM_LINK] = 1'b1;
		if (nvm_dbg_any)
			next_sum[fsh_pkg::SUM_OTP] = 1'b1;
	end

	// summary is registered from masked flags, so it lags the flags by one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			group_fault_summary <= 8'h00;
			fault_out_n <= 1'b1;
		end
		else if (ce)
		begin
			group_fault_summary <= next_sum;
			fault_out_n <= ~(fault_pin_enable & (|next_sum));
		end
	end

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------
	wire aw_take = awvalid & awready;
	wire w_take = wvalid & wready;
	wire wr_commit = ~awready & ~wready & ~bvalid;
	wire wr_mask_a = aw_addr_q == fsh_pkg::OFS_MASK_A;
	wire wr_mask_b = aw_addr_q == fsh_pkg::OFS_MASK_B;
	wire wr_clear_a = aw_addr_q == fsh_pkg::OFS_CLEAR_A;
	wire wr_clear_b = aw_addr_q == fsh_pkg::OFS_CLEAR_B;
	wire wr_config = aw_addr_q == fsh_pkg::OFS_CONFIG;
	wire wr_hit = wr_mask_a | wr_mask_b | wr_clear_a | wr_clear_b | wr_config;
	wire wr_en = wr_commit & w_strb0_q;
	// clear_b shares mask_b's layout, so bits 2:0 land on nvm crc, nvm data, link
	wire [10:0] next_clr = {(wr_en & wr_clear_b) ? w_data_q[2:0] : 3'b000,
		(wr_en & wr_clear_a) ? w_data_q[7:0] : 8'h00};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= fsh_pkg::RESP_OKAY;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb0_q <= 1'b0;
		end
		else if (ce)
		begin
			if (aw_take)
			begin
				awready <= 1'b0;
				aw_addr_q <= {awaddr[11:2], 2'b00};
			end
			if (w_take)
			begin
				wready <= 1'b0;
				w_data_q <= wdata;
				w_strb0_q <= wstrb[0];
			end
			if (wr_commit)
			begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? fsh_pkg::RESP_OKAY : fsh_pkg::RESP_DECERR;
			end
			if (bvalid & bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault_group_mask_a <= fsh_pkg::RST_MASK_A;
			fault_group_mask_b <= fsh_pkg::RST_MASK_B;
			fault_pin_enable <= fsh_pkg::RST_PIN_ENABLE;
			clr_pulse <= 11'h000;
		end
		else if (ce)
		begin
			clr_pulse <= next_clr;
			if (wr_en & wr_mask_a)
				fault_group_mask_a <= w_data_q[7:0];
			if (wr_en & wr_mask_b)
				fault_group_mask_b <= {5'h00, w_data_q[2:0]};
			if (wr_en & wr_config)
				fault_pin_enable <= w_data_q[0];
		end
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	wire [4:0] rd_low_idx = araddr[6:2];
	wire rd_low = (araddr[11:7] == fsh_pkg::OFS_LOW_BASE[11:7]) &
		(rd_low_idx < fsh_pkg::NUM_LOW_W);
	wire [11:0] rd_a = {araddr[11:2], 2'b00};
	wire rd_sum = rd_a == fsh_pkg::OFS_SUMMARY;
	wire rd_ma = rd_a == fsh_pkg::OFS_MASK_A;
	wire rd_mb = rd_a == fsh_pkg::OFS_MASK_B;
	wire rd_clr = (rd_a == fsh_pkg::OFS_CLEAR_A) | (rd_a == fsh_pkg::OFS_CLEAR_B);
	wire rd_cfg = rd_a == fsh_pkg::OFS_CONFIG;
	wire rd_cmd = rd_a == fsh_pkg::OFS_CMD_DETAIL;
	wire rd_resp = rd_a == fsh_pkg::OFS_RESP_DETAIL;
	wire rd_corr = rd_a == fsh_pkg::OFS_NVM_CORR;
	wire rd_uncorr = rd_a == fsh_pkg::OFS_NVM_UNCORR;
	wire rd_hit = rd_low | rd_sum | rd_ma | rd_mb | rd_clr | rd_cfg |
		rd_cmd | rd_resp | rd_corr | rd_uncorr;
	wire [7:0] rd_byte = rd_low ? flag[rd_low_idx] :
		rd_sum ? group_fault_summary :
		rd_ma ? fault_group_mask_a :
		rd_mb ? fault_group_mask_b :
		rd_cfg ? {7'h00, fault_pin_enable} :
		rd_cmd ? cmd_frame_error_detail :
		rd_resp ? resp_frame_error_detail :
		rd_corr ? nvm_corrected_block :
		rd_uncorr ? nvm_uncorrectable_block : 8'h00;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= fsh_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid & arready)
			begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h00_0000, rd_byte};
				rresp <= rd_hit ? fsh_pkg::RESP_OKAY : fsh_pkg::RESP_DECERR;
			end
			else if (rvalid & rready)
			begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wire [7:0] link_flags = flag[fsh_pkg::REG_LINK];
	wire [7:0] prot_flags = flag[0];
	wire prot_regs_clear = (flag[0] == 8'h00) && (flag[1] == 8'h00);
	wire prot_sum_due = !prot_regs_clear && !fault_group_mask_a[0];

	sequence s_clear_issued;
		ce && (clr_pulse != 11'h000);
	endsequence

	sequence s_link_clear_quiet;
		ce && link_clr && (fault_cond[111:104] == 8'h00) &&
			(cmd_frame_cond == 8'h00) && (resp_frame_cond == 8'h00);
	endsequence

	a_flag_holds: assert property (ce && (clr_pulse[fsh_pkg::GRP_PROT] == 1'b0)
		|=> (prot_flags & $past(prot_flags)) == $past(prot_flags))
		else $error("protector flag dropped without clear");
	a_cond_sets: assert property (ce && fault_cond[0] |=> prot_flags[0])
		else $error("fault condition did not latch flag");
	a_persist_keeps: assert property (ce && link_clr && fault_cond[104]
		|=> link_flags[0])
		else $error("flag cleared while condition present");
	a_clear_group: assert property (s_link_clear_quiet
		|=> (link_flags == 8'h00) && (cmd_frame_error_detail == 8'h00) &&
		(resp_frame_error_detail == 8'h00))
		else $error("link group not wiped by clear");
	a_mask_summary: assert property (ce && fault_group_mask_a[0]
		|=> !group_fault_summary[fsh_pkg::SUM_PROT])
		else $error("masked protector group reached summary");
	a_temp_both: assert property (ce && fault_group_mask_a[1] && fault_group_mask_a[2]
		|=> !group_fault_summary[fsh_pkg::SUM_TEMP])
		else $error("temperature summary set with both masks");
	a_pin_disabled: assert property (ce && !fault_pin_enable
		|=> fault_out_n && (group_fault_summary == $past(next_sum)))
		else $error("fault pin driven while disabled");
	a_pin_follow: assert property (ce && fault_pin_enable && (next_sum != 8'h00)
		|=> !fault_out_n)
		else $error("fault pin not driven for unmasked fault");
	a_clear_oneshot: assert property (s_clear_issued ##1 (ce && !wr_commit)
		|=> clr_pulse == 11'h000)
		else $error("clear pulse did not return to zero");
	a_summary_zero: assert property (ce
		|=> group_fault_summary[fsh_pkg::SUM_PROT] == $past(prot_sum_due))
		else $error("protector summary does not follow its registers");
	a_volt_both: assert property (ce && fault_group_mask_a[3] && fault_group_mask_a[4]
		|=> !group_fault_summary[fsh_pkg::SUM_VOLT])
		else $error("voltage summary set with both masks");
	a_nvm_masked: assert property (ce && fault_group_mask_b[0] && fault_group_mask_b[1]
		|=> !group_fault_summary[fsh_pkg::SUM_OTP])
		else $error("nvm summary set with both nvm masks");
	a_link_masked: assert property (ce && fault_group_mask_b[2]
		|=> !group_fault_summary[fsh_pkg::SUM_LINK])
		else $error("link summary set while link group masked");
	a_cmd_detail: assert property (ce
		|=> (cmd_frame_error_detail & $past(cmd_frame_cond)) == $past(cmd_frame_cond))
		else $error("command frame detail missed a condition");

endmodule

// File: sim/fsh_top_test.sv
// testbench: fault status hierarchy checked against a bench model over axi4-lite
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("CHECK FAILED %s expected %h seen %h", n, e, g); \
		end \
	end

module fsh_top_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
	logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [191:0] fault_cond = '0, held = '0;
	logic [31:0] dcond = 32'h0000_0000;
	logic fault_out_n;
	logic [7:0] m_flag [24];
	logic [7:0] m_dbg [4];
	logic [10:0] m_mask;
	logic m_pen;
	int miscompares = 0;
	int n_tests = 0;
	integer seed = 16876;

	always #10 aclk = ~aclk;

	fsh_top i_fsh_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.fault_cond(fault_cond), .cmd_frame_cond(dcond[7:0]),
		.resp_frame_cond(dcond[15:8]), .nvm_corrected_cond(dcond[23:16]),
		.nvm_uncorrectable_cond(dcond[31:24]), .fault_out_n(fault_out_n));

	task automatic conclude();
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		int k;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= 32'(d);
		wstrb <= 4'hf;
		bready <= 1'b1;
		for (k = 0; k < 100; k++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
		end
		if (k == 100)
		begin
			miscompares++;
			conclude();
		end
		`CHK("write response", er, bresp)
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		int k;
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (k = 0; k < 100; k++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
		end
		if (k == 100)
		begin
			miscompares++;
			conclude();
		end
		d = rdata;
		`CHK("read response", er, rresp)
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// ----------------------------------------
	// bench model
	// ----------------------------------------
	// the nvm register splits between the crc mask and the data mask
	function automatic int grp(input int i, input int b);
		if (i == 12)
			return (b < 2) ? 8 : 9;
		return int'(fsh_pkg::REG_GROUP[i]);
	endfunction

	function automatic logic [7:0] exp_sum();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 24; i++)
			for (int b = 0; b < 8; b++)
				if (m_flag[i][b] && !m_mask[grp(i, b)])
					s[fsh_pkg::REG_SUMBIT[i]] = 1'b1;
		if ((m_dbg[0] | m_dbg[1]) != 8'h00 && !m_mask[10])
			s[3] = 1'b1;
		if ((m_dbg[2] | m_dbg[3]) != 8'h00 && !m_mask[9])
			s[2] = 1'b1;
		return s;
	endfunction

	task automatic init_model();
		for (int i = 0; i < 24; i++)
			m_flag[i] = 8'h00;
		for (int k = 0; k < 4; k++)
			m_dbg[k] = 8'h00;
		m_mask = 11'h000;
		m_pen = 1'b1;
	endtask

	task automatic pulse(input logic [191:0] fc, input logic [31:0] dc);
		fault_cond <= held | fc;
		dcond <= dc;
		@(posedge aclk);
		fault_cond <= held;
		dcond <= 32'h0000_0000;
		@(posedge aclk);
		for (int i = 0; i < 24; i++)
			m_flag[i] |= fc[8 * i +: 8] | held[8 * i +: 8];
		for (int k = 0; k < 4; k++)
			m_dbg[k] |= dc[8 * k +: 8];
	endtask

	// a clear cannot drop a bit whose condition is still present
	task automatic clr(input logic [10:0] c);
		wr(fsh_pkg::OFS_CLEAR_A, c[7:0], 2'b00);
		wr(fsh_pkg::OFS_CLEAR_B, 8'(c[10:8]), 2'b00);
		for (int i = 0; i < 24; i++)
			for (int b = 0; b < 8; b++)
				if (c[grp(i, b)])
					m_flag[i][b] = held[8 * i + b];
		if (c[10])
		begin
			m_dbg[0] = 8'h00;
			m_dbg[1] = 8'h00;
		end
		if (c[9])
		begin
			m_dbg[2] = 8'h00;
			m_dbg[3] = 8'h00;
		end
	endtask

	task automatic set_mask(input logic [10:0] m);
		wr(fsh_pkg::OFS_MASK_A, m[7:0], 2'b00);
		wr(fsh_pkg::OFS_MASK_B, 8'(m[10:8]), 2'b00);
		m_mask = m;
	endtask

	task automatic check_all();
		logic [31:0] d;
		logic [7:0] s;
		s = exp_sum();
		for (int i = 0; i < 24; i++)
		begin
			rd(fsh_pkg::OFS_LOW_BASE + 12'(4 * i), 2'b00, d);
			`CHK("low flags", 32'(m_flag[i]), d)
		end
		for (int k = 0; k < 4; k++)
		begin
			rd(fsh_pkg::OFS_CMD_DETAIL + 12'(4 * k), 2'b00, d);
			`CHK("debug detail", 32'(m_dbg[k]), d)
		end
		rd(fsh_pkg::OFS_SUMMARY, 2'b00, d);
		`CHK("summary", 32'(s), d)
		rd(fsh_pkg::OFS_MASK_A, 2'b00, d);
		`CHK("mask a", 32'(m_mask[7:0]), d)
		rd(fsh_pkg::OFS_MASK_B, 2'b00, d);
		`CHK("mask b", 32'(m_mask[10:8]), d)
		`CHK("fault pin", ~(m_pen & (|s)), fault_out_n)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		init_model();
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_all();
		rd(12'h200, 2'b11, d);
		`CHK("unmapped read data", 32'h0000_0000, d)
		wr(fsh_pkg::OFS_SUMMARY, 8'hff, 2'b11);
		rd(fsh_pkg::OFS_CONFIG, 2'b00, d);
		`CHK("pin enable", 32'h0000_0001, d)
		// every group masked alone, then cleared alone
		for (int k = 0; k < 11; k++)
		begin
			set_mask(11'(1 << k));
			pulse({192{1'b1}}, 32'hffff_ffff);
			check_all();
			clr(11'(1 << k));
			check_all();
			clr(11'h7ff);
		end
		rd(fsh_pkg::OFS_CLEAR_A, 2'b00, d);
		`CHK("clear a readback", 32'h0000_0000, d)
		rd(fsh_pkg::OFS_CLEAR_B, 2'b00, d);
		`CHK("clear b readback", 32'h0000_0000, d)
		set_mask(11'h7ff);
		pulse({192{1'b1}}, 32'hffff_ffff);
		check_all();
		// condition still present while its clear is written
		set_mask(11'h000);
		clr(11'h7ff);
		held[47:40] = 8'hff;
		pulse('0, 32'h0000_0000);
		clr(11'h020);
		check_all();
		held = '0;
		pulse('0, 32'h0000_0000);
		check_all();
		clr(11'h020);
		check_all();
		// pin disabled: summary still moves, pin stays high
		wr(fsh_pkg::OFS_CONFIG, 8'h00, 2'b00);
		m_pen = 1'b0;
		pulse(192'h5a, 32'h0000_0000);
		// poll the summary, then read protection register 0 only if the protection bit is set
		rd(fsh_pkg::OFS_SUMMARY, 2'b00, d);
		if (d[fsh_pkg::SUM_PROT])
			rd(fsh_pkg::OFS_LOW_BASE, 2'b00, d);
		`CHK("polled group", 32'(m_flag[0]), d)
		check_all();
		wr(fsh_pkg::OFS_CONFIG, 8'h01, 2'b00);
		m_pen = 1'b1;
		check_all();
		// random faults, masks and clears
		for (int t = 0; t < 12; t++)
		begin
			set_mask(11'($random(seed) & $random(seed)));
			pulse(192'($random(seed) & 8'hff) << (8 * ($unsigned($random(seed)) % 24)),
				$random(seed));
			check_all();
			clr(11'($random(seed)));
			check_all();
		end
		// clock enable low: conditions come and go, nothing may latch
		ce <= 1'b0;
		fault_cond <= {192{1'b1}};
		dcond <= 32'hffff_ffff;
		repeat (3) @(posedge aclk);
		ce <= 1'b1;
		fault_cond <= '0;
		dcond <= 32'h0000_0000;
		@(posedge aclk);
		check_all();
		// reset in mid-run returns every register to its initial value
		pulse(192'h1, 32'h0000_0001);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		init_model();
		@(posedge aclk);
		check_all();
		rd(fsh_pkg::OFS_CONFIG, 2'b00, d);
		`CHK("pin enable after reset", 32'h0000_0001, d)
		conclude();
	end
endmodule
